// ---- pmcs_pkg.sv ----
// Package: register map, field layout and reset values of the power-mode and clock-selection block
package pmcs_pkg;

  // --------------------------------------------------------------------------
  // Register addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] PMCS_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] PMCS_ADDR_SYSCLK_SEL    = 8'h8F;
  localparam logic [7:0] PMCS_ADDR_INT_OSC_CTRL  = 8'hA1;
  localparam logic [7:0] PMCS_ADDR_INT_OSC_CRS   = 8'hA2;
  localparam logic [7:0] PMCS_ADDR_INT_OSC_FIN   = 8'hA3;
  localparam logic [7:0] PMCS_ADDR_EXT_OSC_CTRL  = 8'hA4;
  localparam logic [7:0] PMCS_ADDR_MULT_CTRL     = 8'hA5;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int PMCS_PC_STOP_BIT   = 1;
  localparam int PMCS_PC_IDLE_BIT   = 0;
  localparam int PMCS_PC_GF_LSB     = 2;
  localparam int PMCS_IOSC_EN_BIT   = 7;
  localparam int PMCS_XOSC_VLD_BIT  = 7;
  localparam int PMCS_XOSC_MODE_LSB = 4;
  localparam int PMCS_MULT_EN_BIT   = 7;
  localparam int PMCS_MULT_EXT_BIT  = 6;
  localparam int PMCS_MULT_X4_BIT   = 5;
  localparam int PMCS_CS_ACT_LSB    = 4;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] PMCS_RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] PMCS_RST_SYSCLK_SEL    = 8'h00;
  localparam logic [7:0] PMCS_RST_INT_OSC_CTRL  = 8'h80;
  localparam logic [7:0] PMCS_RST_TRIM          = 8'h00;
  localparam logic [7:0] PMCS_RST_EXT_OSC_CTRL  = 8'h00;
  localparam logic [7:0] PMCS_RST_MULT_CTRL     = 8'h00;
  localparam logic [7:0] PMCS_RD_UNMAPPED       = 8'h00;
  localparam logic [2:0] PMCS_MULT_SCALE_MAX    = 3'h5;

  // Crystal settle count in external oscillator ticks
  localparam int PMCS_XTAL_SETTLE_TICKS = 1024;

  // --------------------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMCS_SRC_INT  = 2'h0,
    PMCS_SRC_EXT  = 2'h1,
    PMCS_SRC_MULT = 2'h2,
    PMCS_SRC_RSV  = 2'h3
  } pmcs_src_t;

  typedef enum logic [2:0] {
    PMCS_XMODE_OFF     = 3'h0,
    PMCS_XMODE_CRYSTAL = 3'h1,
    PMCS_XMODE_RC      = 3'h2,
    PMCS_XMODE_CAP     = 3'h3
  } pmcs_xmode_t;

endpackage : pmcs_pkg

// ---- pmcs_clk_sw_if.sv ----
// Interface: carrier between the register logic and the system clock switch
`timescale 1ns/1ps
interface pmcs_clk_sw_if;
  logic [1:0] req_sel;   // Requested source index
  logic [2:0] src_ok;    // Source enabled and settled
  logic [2:0] src_tick;  // One-cycle source edge strobes
  logic [1:0] cur_sel;   // Source now driving the system clock
  logic       sys_clk;   // Delivered system clock level
  logic       sys_rise;  // Rising edge strobe of sys_clk
  logic       busy;      // Handover in progress

  modport ctrl (output req_sel, output src_ok, output src_tick,
                input cur_sel, input sys_clk, input sys_rise, input busy);
  modport sw   (input req_sel, input src_ok, input src_tick,
                output cur_sel, output sys_clk, output sys_rise, output busy);
endinterface : pmcs_clk_sw_if

// ---- pmcs_clk_switch.sv ----
// Glitch-free system clock switch built from source edge strobes
`timescale 1ns/1ps
module pmcs_clk_switch
  import pmcs_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  srst_i,
  pmcs_clk_sw_if.sw  sw
);

  typedef enum logic [2:0] {
    PMCS_SW_RUN  = 3'b001,
    PMCS_SW_PARK = 3'b010,
    PMCS_SW_ARM  = 3'b100
  } pmcs_sw_state_t;

  pmcs_sw_state_t state_r, state_nxt;
  logic [1:0]     cur_r, cur_nxt;
  logic [1:0]     tgt_r, tgt_nxt;
  logic           clk_r, clk_nxt;

  wire logic cur_tick = sw.src_tick[cur_r];
  wire logic tgt_tick = sw.src_tick[tgt_r];
  wire logic tgt_ok   = sw.src_ok[tgt_r];
  wire logic req_ok   = (sw.req_sel != PMCS_SRC_RSV) && sw.src_ok[sw.req_sel];

  // --------------------------------------------------------------------------
  // Handover: finish the current high phase, hold low, resume on target edge
  // --------------------------------------------------------------------------
  // Parking low before adopting the new source means neither phase is ever cut short
  always_comb begin
    state_nxt = state_r;
    cur_nxt   = cur_r;
    tgt_nxt   = tgt_r;
    clk_nxt   = clk_r;
    case (state_r)
      PMCS_SW_RUN: begin
        if (cur_tick) begin
          clk_nxt = ~clk_r;
        end
        if (sw.req_sel != cur_r && req_ok) begin
          tgt_nxt   = sw.req_sel;
          state_nxt = PMCS_SW_PARK;
        end
      end
      PMCS_SW_PARK: begin
        if (!clk_r) begin
          state_nxt = PMCS_SW_ARM;
        end else if (cur_tick) begin
          clk_nxt   = 1'b0;
          state_nxt = PMCS_SW_ARM;
        end
      end
      PMCS_SW_ARM: begin
        if (!tgt_ok) begin
          state_nxt = PMCS_SW_RUN;             // Target lost: fall back to old source
        end else if (tgt_tick) begin
          cur_nxt   = tgt_r;
          state_nxt = PMCS_SW_RUN;
        end
      end
      default: begin
        state_nxt = PMCS_SW_RUN;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= PMCS_SW_RUN;
      cur_r   <= PMCS_SRC_INT;
      tgt_r   <= PMCS_SRC_INT;
      clk_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r   <= cur_nxt;
      tgt_r   <= tgt_nxt;
      clk_r   <= clk_nxt;
    end
  end

  // Outputs
  assign sw.cur_sel  = cur_r;
  assign sw.sys_clk  = clk_r;
  assign sw.sys_rise = (state_r == PMCS_SW_RUN) && cur_tick && !clk_r;
  assign sw.busy     = (state_r != PMCS_SW_RUN);

endmodule : pmcs_clk_switch

// ---- pmcs_power_clock.sv ----
// Power control register, oscillator control and system clock selection
//
// Notes on behaviour
// - The upper six bits of the power control register are plain software flags with no effect.
// - Writing 1 to bit 1 enters stop mode and halts the internal oscillator; the bit reads as 0.
// - Writing 1 to bit 0 gates only the CPU clock, peripherals keep running; the bit reads as 0.
// - Select code 01 runs the system clock from the external oscillator; 00 picks internal, 10 the multiplier, 11 is ignored.
// - The external oscillator can keep clocking peripherals while the internal oscillator is the system clock.
// - The source may change on the fly, but only to a source that is enabled and settled.
// - The internal oscillator is usable immediately after the write that enables it.
// - External RC and capacitor modes need no start-up interval before selection.
// - Hardware sets the crystal valid flag once the crystal has settled.
// - The multiplier offers internal or external times two or four, scaled by 1 or 2/3 to 2/7.
// - The internal oscillator has an enable and separate coarse and fine trim registers.
`timescale 1ns/1ps
module pmcs_power_clock
  import pmcs_pkg::*;
#(
  parameter int XTAL_SETTLE_TICKS = PMCS_XTAL_SETTLE_TICKS
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_we_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       wake_i,
  input  wire logic       int_osc_tick_i,
  input  wire logic       ext_osc_tick_i,
  input  wire logic       mult_tick_i,
  input  wire logic       mult_locked_i,
  output logic            int_osc_run_o,
  output logic      [6:0] int_osc_coarse_o,
  output logic      [7:0] int_osc_fine_o,
  output logic      [2:0] ext_osc_mode_o,
  output logic      [2:0] ext_osc_range_o,
  output logic            mult_en_o,
  output logic            mult_src_ext_o,
  output logic            mult_x4_o,
  output logic      [2:0] mult_scale_o,
  output logic            sys_clk_o,
  output logic            cpu_clk_en_o,
  output logic            periph_clk_en_o,
  output logic            ext_periph_clk_en_o,
  output logic            idle_o,
  output logic            stop_o
);

  pmcs_clk_sw_if csw ();

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [5:0] general_flags_r;
  logic       idle_r;
  logic       stop_r;
  logic [1:0] clock_source_select_r;
  logic       iosc_en_r;
  logic [6:0] coarse_r;
  logic [7:0] fine_r;
  logic [2:0] xmode_r;
  logic [2:0] xrange_r;
  logic       crystal_valid_flag_r;
  logic [15:0] xtal_cnt_r;
  logic       mult_en_r;
  logic       mult_ext_r;
  logic       mult_x4_r;
  logic [2:0] mult_scale_r;
  logic [7:0] rdata_r;

  // --------------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  wire logic wr_pc   = sfr_we_i && hit(sfr_addr_i, PMCS_ADDR_POWER_CONTROL);
  wire logic wr_cs   = sfr_we_i && hit(sfr_addr_i, PMCS_ADDR_SYSCLK_SEL);
  wire logic wr_io   = sfr_we_i && hit(sfr_addr_i, PMCS_ADDR_INT_OSC_CTRL);
  wire logic wr_crs  = sfr_we_i && hit(sfr_addr_i, PMCS_ADDR_INT_OSC_CRS);
  wire logic wr_fin  = sfr_we_i && hit(sfr_addr_i, PMCS_ADDR_INT_OSC_FIN);
  wire logic wr_xo   = sfr_we_i && hit(sfr_addr_i, PMCS_ADDR_EXT_OSC_CTRL);
  wire logic wr_mult = sfr_we_i && hit(sfr_addr_i, PMCS_ADDR_MULT_CTRL);

  wire logic set_idle = wr_pc && sfr_wdata_i[PMCS_PC_IDLE_BIT];
  wire logic set_stop = wr_pc && sfr_wdata_i[PMCS_PC_STOP_BIT];
  // Scale codes beyond 2/7 are clamped so the divider never sees an undefined ratio
  wire logic [2:0] scale_wr = (sfr_wdata_i[2:0] > PMCS_MULT_SCALE_MAX) ? PMCS_MULT_SCALE_MAX : sfr_wdata_i[2:0];

  // --------------------------------------------------------------------------
  // Power control
  // --------------------------------------------------------------------------
  // Flags are software scratch only; a new request wins over a wake in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      general_flags_r <= PMCS_RST_POWER_CONTROL[7:2];
      idle_r          <= 1'b0;
      stop_r          <= 1'b0;
    end else begin
      if (wr_pc) begin
        general_flags_r <= sfr_wdata_i[7:PMCS_PC_GF_LSB];
      end
      idle_r <= set_idle | (idle_r & ~wake_i);
      stop_r <= set_stop | (stop_r & ~wake_i);
    end
  end

  // --------------------------------------------------------------------------
  // Clock control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clock_source_select_r <= PMCS_RST_SYSCLK_SEL[1:0];
      iosc_en_r             <= PMCS_RST_INT_OSC_CTRL[PMCS_IOSC_EN_BIT];
      coarse_r              <= PMCS_RST_TRIM[6:0];
      fine_r                <= PMCS_RST_TRIM;
      xmode_r               <= PMCS_RST_EXT_OSC_CTRL[6:4];
      xrange_r              <= PMCS_RST_EXT_OSC_CTRL[2:0];
      mult_en_r             <= PMCS_RST_MULT_CTRL[PMCS_MULT_EN_BIT];
      mult_ext_r            <= PMCS_RST_MULT_CTRL[PMCS_MULT_EXT_BIT];
      mult_x4_r             <= PMCS_RST_MULT_CTRL[PMCS_MULT_X4_BIT];
      mult_scale_r          <= PMCS_RST_MULT_CTRL[2:0];
    end else begin
      if (wr_cs) clock_source_select_r <= sfr_wdata_i[1:0];
      if (wr_io) iosc_en_r <= sfr_wdata_i[PMCS_IOSC_EN_BIT];
      if (wr_crs) coarse_r <= sfr_wdata_i[6:0];
      if (wr_fin) fine_r <= sfr_wdata_i;
      if (wr_xo) begin
        xmode_r  <= sfr_wdata_i[PMCS_XOSC_MODE_LSB +: 3];
        xrange_r <= sfr_wdata_i[2:0];
      end
      if (wr_mult) begin
        mult_en_r    <= sfr_wdata_i[PMCS_MULT_EN_BIT];
        mult_ext_r   <= sfr_wdata_i[PMCS_MULT_EXT_BIT];
        mult_x4_r    <= sfr_wdata_i[PMCS_MULT_X4_BIT];
        mult_scale_r <= scale_wr;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Crystal settle detector
  // --------------------------------------------------------------------------
  // Counts oscillator edges after enable; any mode write restarts the count
  wire logic xtal_mode = (xmode_r == PMCS_XMODE_CRYSTAL);
  always_ff @(posedge clk_i) begin
    if (srst_i || wr_xo || !xtal_mode) begin
      xtal_cnt_r           <= 16'h0000;
      crystal_valid_flag_r <= 1'b0;
    end else if (ext_osc_tick_i && !crystal_valid_flag_r) begin
      xtal_cnt_r <= xtal_cnt_r + 16'h0001;
      if (xtal_cnt_r == 16'(XTAL_SETTLE_TICKS - 1)) begin
        crystal_valid_flag_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Source readiness and ticks
  // --------------------------------------------------------------------------
  // Stop halts the internal oscillator; crystal mode counts as ready as soon as the valid flag is set
  assign int_osc_run_o = iosc_en_r && !stop_r;
  wire logic int_ok  = int_osc_run_o;
  wire logic ext_on  = (xmode_r != PMCS_XMODE_OFF);
  wire logic ext_ok  = xtal_mode ? crystal_valid_flag_r : ext_on;
  wire logic base_ok = mult_ext_r ? ext_ok : int_ok;
  wire logic mult_ok = mult_en_r && mult_locked_i && base_ok;

  assign csw.req_sel  = clock_source_select_r;
  assign csw.src_ok   = {mult_ok, ext_ok, int_ok};
  assign csw.src_tick = {mult_tick_i && mult_ok, ext_osc_tick_i && ext_on, int_osc_tick_i && int_ok};

  pmcs_clk_switch u_switch (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .sw     (csw)
  );

  // --------------------------------------------------------------------------
  // Clock enables delivered to the core and peripherals
  // --------------------------------------------------------------------------
  // Idle removes only the CPU enable; peripherals follow the system clock until stop
  assign sys_clk_o           = csw.sys_clk;
  assign periph_clk_en_o     = csw.sys_rise && !stop_r;
  assign cpu_clk_en_o        = csw.sys_rise && !idle_r && !stop_r;
  assign ext_periph_clk_en_o = ext_osc_tick_i && ext_on;
  assign idle_o              = idle_r;
  assign stop_o              = stop_r;
  assign int_osc_coarse_o    = coarse_r;
  assign int_osc_fine_o      = fine_r;
  assign ext_osc_mode_o      = xmode_r;
  assign ext_osc_range_o     = xrange_r;
  assign mult_en_o           = mult_en_r;
  assign mult_src_ext_o      = mult_ext_r;
  assign mult_x4_o           = mult_x4_r;
  assign mult_scale_o        = mult_scale_r;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Request bits always read back as zero
  wire logic [7:0] rd_pc   = {general_flags_r, 2'b00};
  wire logic [7:0] rd_cs   = {2'b00, csw.cur_sel, 2'b00, clock_source_select_r};
  wire logic [7:0] rd_io   = {iosc_en_r, 7'h00};
  wire logic [7:0] rd_xo   = {crystal_valid_flag_r, xmode_r, 1'b0, xrange_r};
  wire logic [7:0] rd_mult = {mult_en_r, mult_ext_r, mult_x4_r, 2'b00, mult_scale_r};
  wire logic [7:0] rd_mux  =
      hit(sfr_addr_i, PMCS_ADDR_POWER_CONTROL) ? rd_pc   :
      hit(sfr_addr_i, PMCS_ADDR_SYSCLK_SEL)    ? rd_cs   :
      hit(sfr_addr_i, PMCS_ADDR_INT_OSC_CTRL)  ? rd_io   :
      hit(sfr_addr_i, PMCS_ADDR_INT_OSC_CRS)   ? {1'b0, coarse_r} :
      hit(sfr_addr_i, PMCS_ADDR_INT_OSC_FIN)   ? fine_r  :
      hit(sfr_addr_i, PMCS_ADDR_EXT_OSC_CTRL)  ? rd_xo   :
      hit(sfr_addr_i, PMCS_ADDR_MULT_CTRL)     ? rd_mult : PMCS_RD_UNMAPPED;

  // Registered read data, one cycle after the address
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= PMCS_RD_UNMAPPED;
    end else begin
      rdata_r <= rd_mux;
    end
  end

  assign sfr_rdata_o = rdata_r;

endmodule : pmcs_power_clock

// ---- pmcs_power_clock_assertions.sv ----
// Checker: port-level properties of the power-mode and clock-select block
`timescale 1ns/1ps
module pmcs_pc_chk
  import pmcs_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_we_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       wake_i,
  input wire logic       int_osc_tick_i,
  input wire logic       ext_osc_tick_i,
  input wire logic       mult_tick_i,
  input wire logic       int_osc_run_o,
  input wire logic [2:0] ext_osc_mode_o,
  input wire logic [2:0] mult_scale_o,
  input wire logic       sys_clk_o,
  input wire logic       cpu_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic       ext_periph_clk_en_o,
  input wire logic       idle_o,
  input wire logic       stop_o
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  // Power control write decode and any source edge
  wire pc_wr = sfr_we_i && (sfr_addr_i == PMCS_ADDR_POWER_CONTROL);
  wire req   = pc_wr && (sfr_wdata_i[1:0] != 2'h0);
  wire tick  = int_osc_tick_i || ext_osc_tick_i || mult_tick_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Request bits never read back as one
  pc_low_a: assert property ($past(sfr_addr_i) == PMCS_ADDR_POWER_CONTROL |-> sfr_rdata_o[1:0] == 2'h0)
    else $error("power control request bits read nonzero");
  idle_set_a: assert property (pc_wr && sfr_wdata_i[0] |=> idle_o)
    else $error("idle request not taken");
  stop_set_a: assert property (pc_wr && sfr_wdata_i[1] |=> stop_o)
    else $error("stop request not taken");
  // A wake clears both modes unless a request lands in the same cycle
  wake_clr_a: assert property (wake_i && !req |=> !idle_o && !stop_o)
    else $error("wake did not clear the mode");
  flag_inert_a: assert property (pc_wr && !req && !idle_o && !stop_o |=> !idle_o && !stop_o)
    else $error("flag write changed the mode");
  stop_gate_a: assert property (stop_o |-> !cpu_clk_en_o && !periph_clk_en_o && !int_osc_run_o)
    else $error("clock running in stop");
  idle_gate_a: assert property (idle_o |-> !cpu_clk_en_o)
    else $error("cpu clock running in idle");
  cpu_periph_a: assert property (cpu_clk_en_o |-> periph_clk_en_o)
    else $error("cpu enable without peripheral enable");
  ext_periph_a: assert property (ext_periph_clk_en_o == (ext_osc_tick_i && ext_osc_mode_o != 3'h0))
    else $error("external peripheral clock wrong");
  scale_max_a: assert property (mult_scale_o <= PMCS_MULT_SCALE_MAX)
    else $error("scale code above the largest divisor");
  // The delivered clock only moves on a source edge, so no phase is cut short
  clk_tick_a: assert property ((sys_clk_o != $past(sys_clk_o)) && !$past(srst_i) |-> $past(tick))
    else $error("system clock moved without a source edge");
  xtal_mode_a: assert property ($past(sfr_addr_i) == PMCS_ADDR_EXT_OSC_CTRL && sfr_rdata_o[7]
    |-> $past(ext_osc_mode_o) == PMCS_XMODE_CRYSTAL)
    else $error("crystal valid outside crystal mode");
  // Main scenarios reached
  idle_c: cover property ($rose(idle_o));
  stop_c: cover property ($rose(stop_o));
  ext_c: cover property ($past(sfr_addr_i) == PMCS_ADDR_SYSCLK_SEL && sfr_rdata_o[5:4] == 2'h1);
endmodule : pmcs_pc_chk

bind pmcs_power_clock pmcs_pc_chk i_chk (
  .clk_i(clk_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_we_i(sfr_we_i), .sfr_rdata_o(sfr_rdata_o), .wake_i(wake_i), .int_osc_tick_i(int_osc_tick_i),
  .ext_osc_tick_i(ext_osc_tick_i), .mult_tick_i(mult_tick_i), .int_osc_run_o(int_osc_run_o),
  .ext_osc_mode_o(ext_osc_mode_o), .mult_scale_o(mult_scale_o), .sys_clk_o(sys_clk_o),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .ext_periph_clk_en_o(ext_periph_clk_en_o), .idle_o(idle_o), .stop_o(stop_o));

// ---- pmcs_power_clock_bench.sv ----
// Testbench: register-driven scenarios for the power-mode and clock-select block
`timescale 1ns/1ps
module pmcs_power_clock_bench;
  import pmcs_pkg::*;
  localparam int SETTLE = 4; // Short settle count keeps the run brief
  logic       clk_i = 1'b0, srst_i = 1'b1, sfr_we_i = 1'b0, wake_i = 1'b0, mult_locked_i = 1'b0;
  logic       int_osc_tick_i = 1'b0, ext_osc_tick_i = 1'b0, mult_tick_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, int_osc_fine_o, v;
  logic [6:0] int_osc_coarse_o;
  logic [2:0] ext_osc_mode_o, ext_osc_range_o, mult_scale_o;
  logic       int_osc_run_o, mult_en_o, mult_src_ext_o, mult_x4_o, sys_clk_o;
  logic       cpu_clk_en_o, periph_clk_en_o, ext_periph_clk_en_o, idle_o, stop_o;
  int         err_total = 0, checks_done = 0, cyc = 0, n_cpu = 0, n_per = 0, n_ext = 0;

  // --------------------------------------------------------------------------
  // Clock, source edges, counters
  // --------------------------------------------------------------------------
  // External edges are sparse so the crystal settle takes visible time
  always #50 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    int_osc_tick_i <= (cyc % 2 == 0);
    ext_osc_tick_i <= (cyc % 4 == 1);
    mult_tick_i    <= (cyc % 2 == 1);
  end
  // Enable pulse counts and the run ceiling
  always @(posedge clk_i) begin
    cyc++;
    n_cpu += (cpu_clk_en_o === 1'b1);
    n_per += (periph_clk_en_o === 1'b1);
    n_ext += (ext_periph_clk_en_o === 1'b1);
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  pmcs_power_clock #(.XTAL_SETTLE_TICKS(SETTLE)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_we_i(sfr_we_i), .sfr_rdata_o(sfr_rdata_o), .wake_i(wake_i), .int_osc_tick_i(int_osc_tick_i),
    .ext_osc_tick_i(ext_osc_tick_i), .mult_tick_i(mult_tick_i), .mult_locked_i(mult_locked_i),
    .int_osc_run_o(int_osc_run_o), .int_osc_coarse_o(int_osc_coarse_o), .int_osc_fine_o(int_osc_fine_o),
    .ext_osc_mode_o(ext_osc_mode_o), .ext_osc_range_o(ext_osc_range_o), .mult_en_o(mult_en_o),
    .mult_src_ext_o(mult_src_ext_o), .mult_x4_o(mult_x4_o), .mult_scale_o(mult_scale_o),
    .sys_clk_o(sys_clk_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .ext_periph_clk_en_o(ext_periph_clk_en_o), .idle_o(idle_o), .stop_o(stop_o));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus cycles start and end at a falling edge; a write ends with an idle cycle so back-to-back
  // writes never raise the strobe in the time step that lowered it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_we_i    = 1'b1;
    @(negedge clk_i);
    sfr_we_i = 1'b0;
    @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    sfr_addr_i = a;
    @(negedge clk_i);
    v = sfr_rdata_o;
  endtask : rd
  // A handover waits on source edges, so poll under a bound
  task automatic src_is(input logic [1:0] s);
    rd(PMCS_ADDR_SYSCLK_SEL);
    for (int i = 0; i < 80 && v[5:4] !== s; i++) rd(PMCS_ADDR_SYSCLK_SEL);
    chk({6'h0, v[5:4]}, {6'h0, s});
  endtask : src_is
  task automatic wake();
    wake_i = 1'b1;
    @(negedge clk_i);
    wake_i = 1'b0;
  endtask : wake

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] a [8] = '{PMCS_ADDR_POWER_CONTROL, PMCS_ADDR_SYSCLK_SEL, PMCS_ADDR_INT_OSC_CTRL,
      PMCS_ADDR_INT_OSC_CRS, PMCS_ADDR_INT_OSC_FIN, PMCS_ADDR_EXT_OSC_CTRL, PMCS_ADDR_MULT_CTRL, 8'h50};
    logic [7:0] e [8] = '{PMCS_RST_POWER_CONTROL, PMCS_RST_SYSCLK_SEL, PMCS_RST_INT_OSC_CTRL,
      PMCS_RST_TRIM, PMCS_RST_TRIM, PMCS_RST_EXT_OSC_CTRL, PMCS_RST_MULT_CTRL, PMCS_RD_UNMAPPED};
    srst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    wr(8'h50, 8'hFF);
    foreach (a[i]) begin
      rd(a[i]);
      chk(v, e[i]);
    end
  endtask : t_reset
  task automatic t_modes();
    wr(PMCS_ADDR_POWER_CONTROL, 8'hFC);
    rd(PMCS_ADDR_POWER_CONTROL);
    chk(v, 8'hFC);
    chk({6'h0, idle_o, stop_o}, 8'h00);
    wr(PMCS_ADDR_POWER_CONTROL, 8'h05);
    rd(PMCS_ADDR_POWER_CONTROL);
    chk(v, 8'h04);
    n_cpu = 0;
    n_per = 0;
    repeat (40) @(negedge clk_i);
    chk({5'h0, idle_o, n_cpu == 0, n_per > 0}, 8'h07);
    wake();
    wr(PMCS_ADDR_POWER_CONTROL, 8'h02);
    rd(PMCS_ADDR_POWER_CONTROL);
    chk(v, 8'h00);
    n_cpu = 0;
    n_per = 0;
    repeat (40) @(negedge clk_i);
    chk({4'h0, int_osc_run_o, stop_o, n_cpu == 0, n_per == 0}, 8'h07);
    wake();
    n_cpu = 0;
    repeat (40) @(negedge clk_i);
    chk({5'h0, int_osc_run_o, stop_o, n_cpu > 0}, 8'h05);
  endtask : t_modes
  task automatic t_ext();
    wr(PMCS_ADDR_EXT_OSC_CTRL, 8'h23);
    chk({2'h0, ext_osc_mode_o, ext_osc_range_o}, 8'h13);
    n_ext = 0;
    repeat (20) @(negedge clk_i);
    chk({7'h0, n_ext > 0}, 8'h01);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h01);
    src_is(2'h1);
    // Disabled internal source must not be taken; enabling it allows the switch at once
    wr(PMCS_ADDR_INT_OSC_CTRL, 8'h00);
    chk({7'h0, int_osc_run_o}, 8'h00);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h00);
    repeat (12) @(negedge clk_i);
    src_is(2'h1);
    wr(PMCS_ADDR_INT_OSC_CTRL, 8'h80);
    src_is(2'h0);
    wr(PMCS_ADDR_INT_OSC_CRS, 8'hFF);
    wr(PMCS_ADDR_INT_OSC_FIN, 8'hA5);
    chk({1'b0, int_osc_coarse_o}, 8'h7F);
    chk(int_osc_fine_o, 8'hA5);
    // Capacitor mode is ready at once as well
    wr(PMCS_ADDR_EXT_OSC_CTRL, 8'h35);
    chk({2'h0, ext_osc_mode_o, ext_osc_range_o}, 8'h1D);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h01);
    src_is(2'h1);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h00);
    src_is(2'h0);
  endtask : t_ext
  task automatic t_xtal();
    wr(PMCS_ADDR_EXT_OSC_CTRL, 8'h10);
    rd(PMCS_ADDR_EXT_OSC_CTRL);
    chk({7'h0, v[7]}, 8'h00);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h01);
    repeat (4) @(negedge clk_i);
    src_is(2'h0);
    repeat (30) @(negedge clk_i);
    rd(PMCS_ADDR_EXT_OSC_CTRL);
    chk({7'h0, v[7]}, 8'h01);
    src_is(2'h1);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h00);
    src_is(2'h0);
  endtask : t_xtal
  task automatic t_mult();
    for (int s = 0; s < 8; s++) begin
      wr(PMCS_ADDR_MULT_CTRL, 8'hE0 | 8'(s));
      chk({5'h0, mult_scale_o}, (s > 5) ? 8'h05 : 8'(s));
    end
    chk({5'h0, mult_en_o, mult_src_ext_o, mult_x4_o}, 8'h07);
    wr(PMCS_ADDR_MULT_CTRL, 8'h80);
    chk({5'h0, mult_en_o, mult_src_ext_o, mult_x4_o}, 8'h04);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h02);
    repeat (12) @(negedge clk_i);
    src_is(2'h0);
    mult_locked_i = 1'b1;
    src_is(2'h2);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h03);
    repeat (12) @(negedge clk_i);
    src_is(2'h2);
    wr(PMCS_ADDR_SYSCLK_SEL, 8'h00);
    src_is(2'h0);
  endtask : t_mult

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // Main sequence, ending with a reset in mid-run
  initial begin
    t_reset();
    t_modes();
    t_ext();
    t_xtal();
    t_mult();
    t_reset();
    complete_run();
  end
endmodule : pmcs_power_clock_bench
